//--- rtl/setm_pkg.sv
// setm_pkg: shared constants and types of the serial-presence-detect
// eeprom with thermal monitor.
// assumes a 20 MHz core clock; nothing here is clocked.
package setm_pkg;

  // timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned WR_TIME_MS = 5;
  localparam int unsigned WR_CYCLES = CLK_HZ / 1000 * WR_TIME_MS;
  localparam int unsigned CONV_TIME_MS = 125;
  localparam int unsigned CONV_CYCLES = CLK_HZ / 1000 * CONV_TIME_MS;
  localparam int unsigned SCL_I2C_MAX_HZ = 1_000_000;
  localparam int unsigned SCL_SMB_MAX_HZ = 100_000;

  // storage layout
  localparam int unsigned MEM_BYTES = 512;
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned BLOCK_BYTES = 128;
  localparam int unsigned WPAGE_BYTES = 16;

  // device type codes
  localparam logic [3:0] DT_MEM = 4'hA;
  localparam logic [3:0] DT_PROT = 4'h6;
  localparam logic [3:0] DT_TH = 4'h3;

  // protection command select fields
  localparam logic [2:0] LSA_SWP0 = 3'h1;
  localparam logic [2:0] LSA_SWP1 = 3'h4;
  localparam logic [2:0] LSA_SWP2 = 3'h5;
  localparam logic [2:0] LSA_SWP3 = 3'h0;
  localparam logic [2:0] LSA_CWP = 3'h3;

  // thermal register pointers
  localparam logic [3:0] PTR_CAP = 4'h0;
  localparam logic [3:0] PTR_CFG = 4'h1;
  localparam logic [3:0] PTR_HI = 4'h2;
  localparam logic [3:0] PTR_LO = 4'h3;
  localparam logic [3:0] PTR_CRIT = 4'h4;
  localparam logic [3:0] PTR_TEMP = 4'h5;
  localparam logic [3:0] PTR_RES = 4'h8;

  // configuration fields
  localparam int unsigned CFG_INT_BIT = 0;
  localparam int unsigned CFG_POL_BIT = 1;
  localparam int unsigned CFG_CRIT_BIT = 2;
  localparam int unsigned CFG_CLR_BIT = 5;
  localparam int unsigned CFG_SHDN_BIT = 8;
  localparam int unsigned CFG_HYS_LSB = 9;
  localparam int unsigned CFG_SRST_BIT = 15;
  localparam logic [15:0] CFG_WMASK = 16'h0707;

  // reset values and fixed reads
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [12:0] LIM_RST = 13'h0000;
  localparam logic [12:0] LIM_MASK = 13'h1FFC;
  localparam logic [1:0] RES_RST = 2'h1;
  localparam logic [15:0] CAP_VAL = 16'h0001;

  // hysteresis in sixteenths of a degree: 0, 1.5, 3, 6
  localparam logic [12:0] HYS_0 = 13'h0000;
  localparam logic [12:0] HYS_1 = 13'h0018;
  localparam logic [12:0] HYS_2 = 13'h0030;
  localparam logic [12:0] HYS_3 = 13'h0060;

  // serial engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_WR = 2'b10,
    ST_RD = 2'b11
  } setm_state_t;

endpackage

//--- rtl/setm_alarm.sv
// setm_alarm: limit comparison with hysteresis and event behaviour.
// assumes limits and reading are two's complement sixteenths of a degree
// from the same clock domain.
`timescale 1ns/1ns
module setm_alarm (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // latched reading and limits
  input wire logic [12:0] temp,
  input wire logic [12:0] hi_lim,
  input wire logic [12:0] lo_lim,
  input wire logic [12:0] crit_lim,
  // behaviour
  input wire logic [1:0] hyst_sel,
  input wire logic int_mode,
  input wire logic crit_only,
  input wire logic clr,
  // result, true when the event is active
  output logic alarm
);
  logic hi_q, lo_q, cr_q, int_q, win_old_q, alarm_q;
  logic [12:0] hys;
  logic signed [13:0] t, h, hi, lo, cr;
  logic win, int_set;

  // one extra bit keeps limit minus hysteresis from wrapping
  assign hys = (hyst_sel == 2'h0) ? setm_pkg::HYS_0 :
               (hyst_sel == 2'h1) ? setm_pkg::HYS_1 :
               (hyst_sel == 2'h2) ? setm_pkg::HYS_2 : setm_pkg::HYS_3;
  assign t = {temp[12], temp};
  assign h = {1'b0, hys};
  assign hi = {hi_lim[12], hi_lim};
  assign lo = {lo_lim[12], lo_lim};
  assign cr = {crit_lim[12], crit_lim};
  assign win = hi_q | lo_q;
  assign int_set = win & !win_old_q;

  // window and critical comparators, released past the hysteresis
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hi_q <= 1'b0;
      lo_q <= 1'b0;
      cr_q <= 1'b0;
      win_old_q <= 1'b0;
    end else begin
      hi_q <= (t > hi) | (hi_q & !(t < hi - h));
      lo_q <= (t < lo) | (lo_q & !(t > lo + h));
      cr_q <= (t > cr) | (cr_q & !(t < cr - h));
      win_old_q <= win;
    end
  end

  // latched event: a new crossing in the clear cycle still sets
  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_q <= 1'b0;
    end else if (int_set) begin
      int_q <= 1'b1;
    end else if (clr) begin
      int_q <= 1'b0;
    end
  end

  // critical always behaves as a comparator
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= crit_only ? cr_q : (cr_q | (int_mode ? int_q : win));
    end
  end

  assign alarm = alarm_q;
endmodule // setm_alarm

//--- rtl/setm_core.sv
// setm_core: two-wire slave holding a 512-byte eeprom image with
// reversible block protection and a thermal monitor register set.
// assumes the host owns scl and an external pull-up on sda and event;
// the converter delivers temp_code with temp_valid on core_clk.
`timescale 1ns/1ns
module setm_core #(
  parameter int unsigned WR_CYCLES = setm_pkg::WR_CYCLES,
  parameter int unsigned CONV_CYCLES = setm_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial link, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // address select straps and high-voltage detect
  input wire logic select_addr_in0,
  input wire logic select_addr_in1,
  input wire logic select_addr_in2,
  input wire logic elevated_detect_voltage,
  // converter
  input wire logic [12:0] temp_code,
  input wire logic temp_valid,
  output logic conv_req,
  // event pin, open drain
  output logic event_out,
  output logic event_oe,
  // status
  output logic wr_busy
);
  // synchroniser and edge detect
  logic [5:0] m1_q, m2_q;
  logic [1:0] old_q;
  logic [5:0] pins;
  logic scl, sda, hv, scl_rise, scl_fall, start, stop;
  logic [2:0] sel;

  // serial engine
  setm_pkg::setm_state_t state_q;
  logic [3:0] cnt_q;
  logic in_ack_q, oe_q, mack_q, first_q, sec_q;
  logic [7:0] sh_q, tx_q, addr_q, msb_q;
  logic [1:0] bidx_q;
  logic [3:0] ptr_q;
  logic page_q;
  logic [3:0] prot_q;
  logic [7:0] buf_q [16];
  logic [15:0] vld_q;

  // write cycle and storage
  logic busy_q;
  logic [31:0] tmr_q;
  logic [4:0] ci_q;
  logic [4:0] wline_q;
  logic [7:0] mem_q [512];

  // thermal section
  logic [15:0] cfg_q;
  logic [12:0] hi_q, lo_q, cr_q, temp_q;
  logic [1:0] res_q;
  logic [31:0] ccnt_q;
  logic conv_q, event_q, alarm;

  // decode
  logic [3:0] dt;
  logic [2:0] logical_select_address;
  logic rw, mem_hit, th_hit, pr_hit, pr_ack, addr_ack, wr_ack;
  logic is_swp, is_cwp, is_pg;
  logic [1:0] pblk;
  logic byte_done, ack_end, rd_shift, commit_go;
  logic th_we, th_clr, th_srst, shdn;
  logic [15:0] th_wd, th_rd;
  logic [7:0] rd_byte;
  logic [12:0] res_mask;
  logic f_cr, f_hi, f_lo;

  // pins are asynchronous: two flops before anything looks at them
  assign pins = {elevated_detect_voltage, select_addr_in2,
                 select_addr_in1, select_addr_in0, sda_in, scl_in};
  always_ff @(posedge core_clk) begin
    if (rst) begin
      m1_q <= 6'h03;
      m2_q <= 6'h03;
      old_q <= 2'h3;
    end else begin
      m1_q <= pins;
      m2_q <= m1_q;
      old_q <= m2_q[1:0];
    end
  end

  // line conditions; 1 MHz scl still leaves several samples per phase
  assign scl = m2_q[0];
  assign sda = m2_q[1];
  assign sel = m2_q[4:2];
  assign hv = m2_q[5];
  assign scl_rise = scl & !old_q[0];
  assign scl_fall = !scl & old_q[0];
  assign start = scl & old_q[0] & !sda & old_q[1];
  assign stop = scl & old_q[0] & sda & !old_q[1];

  // address byte decode
  assign dt = sh_q[7:4];
  assign logical_select_address = sh_q[3:1];
  assign rw = sh_q[0];
  assign mem_hit = (dt == setm_pkg::DT_MEM) & (logical_select_address == sel) & !busy_q;
  assign th_hit = (dt == setm_pkg::DT_TH) & (logical_select_address == sel);
  assign pr_hit = (dt == setm_pkg::DT_PROT);

  // protection commands ignore the straps; only sda and hv count
  assign is_swp = (logical_select_address == setm_pkg::LSA_SWP0) | (logical_select_address == setm_pkg::LSA_SWP1) |
                  (logical_select_address == setm_pkg::LSA_SWP2) | (logical_select_address == setm_pkg::LSA_SWP3);
  assign is_cwp = (logical_select_address == setm_pkg::LSA_CWP);
  assign is_pg = (logical_select_address[2:1] == 2'h3);
  assign pblk = (logical_select_address == setm_pkg::LSA_SWP0) ? 2'h0 :
                (logical_select_address == setm_pkg::LSA_SWP1) ? 2'h1 :
                (logical_select_address == setm_pkg::LSA_SWP2) ? 2'h2 : 2'h3;
  // the remaining select code (permanent lock on older parts) is refused
  assign pr_ack = is_swp ? (!prot_q[pblk] & (rw | hv)) :
                  is_cwp ? (!rw & hv) :
                  is_pg ? (!rw | (page_q == logical_select_address[0])) : 1'b0;
  assign addr_ack = mem_hit | th_hit | (pr_hit & pr_ack);

  // data byte acceptance: locked blocks refuse data, not the address
  assign wr_ack = sec_q ? (bidx_q != 2'h3) :
                  ((bidx_q == 2'h0) | !prot_q[{page_q, addr_q[7]}]);

  // bit timing strobes
  assign byte_done = scl_fall & !in_ack_q & (cnt_q == 4'h8);
  assign ack_end = scl_fall & in_ack_q;
  assign rd_shift = scl_fall & !in_ack_q & (state_q == setm_pkg::ST_RD) &
                    (cnt_q != 4'h0) & (cnt_q != 4'h8);
  assign commit_go = stop & (state_q == setm_pkg::ST_WR) & !sec_q &
                     (|vld_q);

  // read data: thermal words go out high byte first
  assign rd_byte = sec_q ? (bidx_q[0] ? th_rd[7:0] : th_rd[15:8]) :
                   mem_q[{page_q, addr_q}];

  // serial engine: sample on scl rise, drive sda on scl fall
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= setm_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      in_ack_q <= 1'b0;
      oe_q <= 1'b0;
      mack_q <= 1'b0;
      first_q <= 1'b0;
      sec_q <= 1'b0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= 8'h00;
      msb_q <= 8'h00;
      bidx_q <= 2'h0;
      ptr_q <= 4'h0;
      page_q <= 1'b0;
      prot_q <= 4'h0;
      vld_q <= 16'h0000;
    end else if (start) begin
      state_q <= setm_pkg::ST_ADDR;
      cnt_q <= 4'h0;
      in_ack_q <= 1'b0;
      oe_q <= 1'b0;
      bidx_q <= 2'h0;
    end else if (stop) begin
      state_q <= setm_pkg::ST_IDLE;
      oe_q <= 1'b0;
    end else if (state_q != setm_pkg::ST_IDLE) begin
      if (scl_rise & !in_ack_q & (cnt_q != 4'h8)) begin
        sh_q <= {sh_q[6:0], sda};
        cnt_q <= cnt_q + 4'h1;
      end
      if (scl_rise & in_ack_q) begin
        mack_q <= !sda;
      end
      if (byte_done) begin
        in_ack_q <= 1'b1;
        case (state_q)
          setm_pkg::ST_ADDR: begin
            oe_q <= addr_ack;
            first_q <= 1'b1;
            sec_q <= th_hit;
            if (!addr_ack) begin
              state_q <= setm_pkg::ST_IDLE;
            end else if (rw) begin
              state_q <= setm_pkg::ST_RD;
            end else begin
              state_q <= setm_pkg::ST_WR;
            end
            if (mem_hit & !rw) begin
              vld_q <= 16'h0000;
            end
            if (pr_hit & pr_ack & !rw & is_swp) begin
              prot_q[pblk] <= 1'b1;
            end
            if (pr_hit & pr_ack & is_cwp) begin
              prot_q <= 4'h0;
            end
            if (pr_hit & !rw & is_pg) begin
              page_q <= logical_select_address[0];
            end
          end
          setm_pkg::ST_WR: begin
            oe_q <= wr_ack;
            bidx_q <= (bidx_q == 2'h3) ? bidx_q : bidx_q + 2'h1;
            if (!wr_ack) begin
              state_q <= setm_pkg::ST_IDLE;
            end else if (!sec_q & (bidx_q == 2'h0)) begin
              addr_q <= sh_q;
            end else if (!sec_q) begin
              // extra bytes wrap inside the 16-byte line
              buf_q[addr_q[3:0]] <= sh_q;
              vld_q[addr_q[3:0]] <= 1'b1;
              addr_q[3:0] <= addr_q[3:0] + 4'h1;
            end else if (bidx_q == 2'h0) begin
              ptr_q <= sh_q[3:0];
            end else if (bidx_q == 2'h1) begin
              msb_q <= sh_q;
            end
          end
          default: begin
            oe_q <= 1'b0;
          end
        endcase
      end
      if (ack_end) begin
        in_ack_q <= 1'b0;
        cnt_q <= 4'h0;
        oe_q <= 1'b0;
        if ((state_q == setm_pkg::ST_RD) & (first_q | mack_q)) begin
          tx_q <= rd_byte;
          oe_q <= !rd_byte[7];
          first_q <= 1'b0;
          if (sec_q) begin
            bidx_q <= bidx_q + 2'h1;
          end else begin
            addr_q <= addr_q + 8'h01;
          end
        end else if (state_q == setm_pkg::ST_RD) begin
          state_q <= setm_pkg::ST_IDLE;
        end
      end
      if (rd_shift) begin
        tx_q <= {tx_q[6:0], 1'b0};
        oe_q <= !tx_q[6];
      end
    end
  end

  // programming cycle: copy the line, then stay busy for the full time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      tmr_q <= 32'h0000_0000;
      ci_q <= 5'h00;
      wline_q <= 5'h00;
    end else if (commit_go) begin
      busy_q <= 1'b1;
      tmr_q <= 32'h0000_0000;
      ci_q <= 5'h00;
      wline_q <= {page_q, addr_q[7:4]};
    end else if (busy_q) begin
      tmr_q <= tmr_q + 32'h0000_0001;
      if (!ci_q[4]) begin
        ci_q <= ci_q + 5'h01;
      end
      if (tmr_q == 32'(WR_CYCLES - 1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  // eeprom image is nonvolatile: no reset on purpose
  always_ff @(posedge core_clk) begin
    if (busy_q & !ci_q[4] & vld_q[ci_q[3:0]]) begin
      mem_q[{wline_q, ci_q[3:0]}] <= buf_q[ci_q[3:0]];
    end
  end

  // thermal register writes happen when the low byte is taken
  assign th_we = byte_done & (state_q == setm_pkg::ST_WR) & sec_q &
                 (bidx_q == 2'h2);
  assign th_wd = {msb_q, sh_q};
  assign th_clr = th_we & (ptr_q == setm_pkg::PTR_CFG) &
                  th_wd[setm_pkg::CFG_CLR_BIT];
  assign th_srst = th_we & (ptr_q == setm_pkg::PTR_CFG) &
                   th_wd[setm_pkg::CFG_SRST_BIT];
  assign shdn = cfg_q[setm_pkg::CFG_SHDN_BIT];
  assign res_mask = 13'h1FFF << (2'h3 - res_q);

  // configuration and limits; soft reset returns them to defaults
  always_ff @(posedge core_clk) begin
    if (rst | th_srst) begin
      cfg_q <= setm_pkg::CFG_RST;
      hi_q <= setm_pkg::LIM_RST;
      lo_q <= setm_pkg::LIM_RST;
      cr_q <= setm_pkg::LIM_RST;
      res_q <= setm_pkg::RES_RST;
    end else if (th_we) begin
      case (ptr_q)
        setm_pkg::PTR_CFG: cfg_q <= th_wd & setm_pkg::CFG_WMASK;
        setm_pkg::PTR_HI: hi_q <= th_wd[12:0] & setm_pkg::LIM_MASK;
        setm_pkg::PTR_LO: lo_q <= th_wd[12:0] & setm_pkg::LIM_MASK;
        setm_pkg::PTR_CRIT: cr_q <= th_wd[12:0] & setm_pkg::LIM_MASK;
        setm_pkg::PTR_RES: res_q <= th_wd[1:0];
        default: res_q <= res_q;
      endcase
    end
  end

  // conversion pacing: a request every 125 ms unless shut down
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ccnt_q <= 32'h0000_0000;
      conv_q <= 1'b0;
    end else begin
      ccnt_q <= (ccnt_q == 32'(CONV_CYCLES - 1)) ? 32'h0000_0000 :
                ccnt_q + 32'h0000_0001;
      conv_q <= (ccnt_q == 32'h0000_0000) & !shdn;
    end
  end

  // latest result held for reads at any time; frozen while shut down
  always_ff @(posedge core_clk) begin
    if (rst) begin
      temp_q <= 13'h0000;
    end else if (temp_valid & !shdn) begin
      temp_q <= temp_code & res_mask;
    end
  end

  // live flags shown beside the reading
  assign f_cr = $signed(temp_q) > $signed(cr_q);
  assign f_hi = $signed(temp_q) > $signed(hi_q);
  assign f_lo = $signed(temp_q) < $signed(lo_q);
  assign th_rd = (ptr_q == setm_pkg::PTR_CAP) ? setm_pkg::CAP_VAL :
                 (ptr_q == setm_pkg::PTR_CFG) ? cfg_q :
                 (ptr_q == setm_pkg::PTR_HI) ? {3'h0, hi_q} :
                 (ptr_q == setm_pkg::PTR_LO) ? {3'h0, lo_q} :
                 (ptr_q == setm_pkg::PTR_CRIT) ? {3'h0, cr_q} :
                 (ptr_q == setm_pkg::PTR_TEMP) ? {f_cr, f_hi, f_lo, temp_q} :
                 (ptr_q == setm_pkg::PTR_RES) ? {14'h0000, res_q} : 16'h0000;

  // comparator, hysteresis and event behaviour
  setm_alarm u_alarm (
    .core_clk(core_clk),
    .rst(rst | th_srst),
    .temp(temp_q),
    .hi_lim(hi_q),
    .lo_lim(lo_q),
    .crit_lim(cr_q),
    .hyst_sel(cfg_q[setm_pkg::CFG_HYS_LSB +: 2]),
    .int_mode(cfg_q[setm_pkg::CFG_INT_BIT]),
    .crit_only(cfg_q[setm_pkg::CFG_CRIT_BIT]),
    .clr(th_clr),
    .alarm(alarm)
  );

  // open drain event: active high means release while asserted
  always_ff @(posedge core_clk) begin
    if (rst) begin
      event_q <= 1'b0;
    end else begin
      event_q <= alarm ^ cfg_q[setm_pkg::CFG_POL_BIT];
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign event_out = 1'b0;
  assign event_oe = event_q;
  assign wr_busy = busy_q;
  assign conv_req = conv_q;
endmodule // setm_core

//--- tb/setm_core_props.sv
// setm_core_props: port-level timing checks for setm_core.
// assumes it is bound into every setm_core and sees only its ports.
`timescale 1ns/1ns
module setm_core_props #(
  parameter int unsigned WR_CYCLES = 40,
  parameter int unsigned CONV_CYCLES = 50
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial link
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  // status
  input wire logic conv_req,
  input wire logic wr_busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // running busy length and gap since the last conversion request
  logic [31:0] busy_q;
  logic [31:0] gap_q;
  logic seen_q;
  always_ff @(posedge core_clk) begin
    busy_q <= (rst || !wr_busy) ? 32'h0 : busy_q + 32'h1;
    gap_q <= (rst || conv_req) ? 32'h0 : gap_q + 32'h1;
    seen_q <= !rst && (seen_q || conv_req);
  end
  // a programming cycle starts only once a stop has left both lines high
  sequence s_busy_go;
    $rose(wr_busy);
  endsequence
  sequence s_bus_idle;
    scl_in && sda_in;
  endsequence
  property p_rst_quiet;
    disable iff (1'b0) rst |=> !sda_oe && !conv_req && !wr_busy;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("not quiet");
  property p_busy_max;
    wr_busy |-> busy_q < WR_CYCLES;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy long");
  property p_busy_hold;
    s_busy_go |=> wr_busy [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy short");
  property p_busy_stop;
    s_busy_go |-> s_bus_idle;
  endproperty
  a_busy_stop: assert property (p_busy_stop) else $error("busy early");
  property p_conv_pulse;
    conv_req |=> !conv_req [*8];
  endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("conv");
  // a too-short gap would mean a conversion was cut short
  property p_conv_gap;
    conv_req && seen_q |-> gap_q >= CONV_CYCLES - 1;
  endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("conv gap");
  property p_oe_scl;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("sda moved");
  property p_oe_hold;
    $rose(sda_oe) |=> sda_oe [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("sda short");
endmodule // setm_core_props

bind setm_core setm_core_props #(
  .WR_CYCLES(WR_CYCLES),
  .CONV_CYCLES(CONV_CYCLES)
) u_setm_core_props (
  .core_clk, .rst, .scl_in, .sda_in, .sda_oe, .conv_req, .wr_busy
);

//--- tb/setm_host.sv
// setm_host: behavioural two-wire host clocking bytes in and out.
// assumes sda is the resolved wire with a pull-up, on core_clk.
`timescale 1ns/1ns
module setm_host (
  // clock
  input wire logic core_clk,
  // resolved data wire
  input wire logic sda,
  // host pins: clock level and data pull-down
  output logic scl,
  output logic sda_pull
);
  // five core cycles a quarter bit keeps scl at 1 MHz
  localparam int QTR = 5;
  // idle bus from time zero
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // one quarter bit; pins move only just after a rising edge
  task automatic qb(input logic c, input logic p);
    scl <= c;
    sda_pull <= p;
    repeat (QTR) @(posedge core_clk);
  endtask
  // data falls while clock high; also serves as repeated start
  task automatic start();
    qb(1'b0, sda_pull);
    qb(1'b0, 1'b0);
    qb(1'b1, 1'b0);
    qb(1'b1, 1'b1);
  endtask
  // data rises while clock high; extra quarter lets busy show
  task automatic stop();
    qb(1'b0, sda_pull);
    qb(1'b0, 1'b1);
    qb(1'b1, 1'b1);
    qb(1'b1, 1'b0);
    qb(1'b1, 1'b0);
  endtask
  // eight bits msb first then the ninth; q holds the wire per bit
  task automatic xb(input logic [7:0] d, input logic ab,
                    output logic [8:0] q);
    logic [8:0] w;
    w = {d, ab};
    for (int i = 8; i >= 0; i--) begin
      qb(1'b0, sda_pull);
      qb(1'b0, ~w[i]);
      qb(1'b1, ~w[i]);
      q[i] = sda;
      qb(1'b1, ~w[i]);
    end
  endtask
endmodule // setm_host

//--- tb/tb_top.sv
// tb_top: directed bench for setm_core through the host model.
// assumes sda has a pull-up and the converter is played by the bench.
`timescale 1ns/1ns
module tb_top;
  logic core_clk;
  logic rst;
  logic scl;
  logic sda_pull;
  logic sda;
  logic [2:0] sel;
  logic hv;
  logic [12:0] temp_code;
  logic temp_valid;
  logic sda_out, sda_oe, conv_req, event_out, event_oe, wr_busy;
  logic [8:0] q;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int c;
  // open-drain wire: low while either side pulls
  assign sda = ~(sda_pull | sda_oe);
  setm_core #(.WR_CYCLES(400), .CONV_CYCLES(50)) u_setm_core (
    .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .select_addr_in0(sel[0]),
    .select_addr_in1(sel[1]), .select_addr_in2(sel[2]),
    .elevated_detect_voltage(hv), .temp_code(temp_code),
    .temp_valid(temp_valid), .conv_req(conv_req), .event_out(event_out),
    .event_oe(event_oe), .wr_busy(wr_busy));
  setm_host u_setm_host (.core_clk(core_clk), .sda(sda), .scl(scl),
    .sda_pull(sda_pull));
  // 50 ns clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic ck1(input logic s, input logic e);
    chk({15'h0000, s}, {15'h0000, e});
  endtask
  // one byte out, acknowledge compared with e
  task automatic snd(input logic [7:0] d, input logic e);
    u_setm_host.xb(d, 1'b1, q);
    ck1(~q[0], e);
  endtask
  task automatic rd(input logic last, input logic [7:0] e);
    u_setm_host.xb(8'hFF, last, q);
    chk({8'h00, q[8:1]}, {8'h00, e});
  endtask
  task automatic cmd(input logic [7:0] a, input logic e);
    u_setm_host.start();
    snd(a, e);
    u_setm_host.stop();
  endtask
  // protection read: the data byte is clocked out only when an ack is expected
  task automatic pchk(input logic [7:0] a, input logic e);
    u_setm_host.start();
    snd(a, e);
    if (e)
      u_setm_host.xb(8'hFF, 1'b1, q);
    u_setm_host.stop();
  endtask
  task automatic wt();
    for (int n = 0; n < 1000 && wr_busy !== 1'b0; n++)
      @(posedge core_clk);
    ck1(wr_busy, 1'b0);
  endtask
  task automatic tw(input logic [3:0] p, input logic [15:0] v);
    u_setm_host.start();
    snd(8'h3A, 1'b1);
    snd({4'h0, p}, 1'b1);
    snd(v[15:8], 1'b1);
    snd(v[7:0], 1'b1);
    u_setm_host.stop();
  endtask
  // window from -0.5 to 4 degrees, critical at 8 degrees; with zero
  // hysteresis a reading equal to a limit would keep the event held
  task automatic lim();
    tw(setm_pkg::PTR_HI, 16'h0040);
    tw(setm_pkg::PTR_LO, 16'h1FF8);
    tw(setm_pkg::PTR_CRIT, 16'h0080);
  endtask
  // converter sample, then room for the event path to settle
  task automatic tf(input logic [12:0] t);
    temp_code <= t;
    temp_valid <= 1'b1;
    @(posedge core_clk);
    temp_valid <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask
  task automatic cc(output int n);
    n = 0;
    repeat (120) begin
      @(posedge core_clk);
      if (conv_req === 1'b1)
        n++;
    end
  endtask
  // a hang counts as a mismatch
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    sel = 3'h5;
    hv = 1'b0;
    temp_code = 13'h0000;
    temp_valid = 1'b0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    ck1(wr_busy, 1'b0);
    ck1(sda_out | event_out, 1'b0);
    // full page write; the memory code is refused while busy
    u_setm_host.start();
    snd(8'hAA, 1'b1);
    snd(8'h20, 1'b1);
    for (int i = 0; i < 16; i++)
      snd(8'h40 + 8'(i), 1'b1);
    u_setm_host.stop();
    ck1(wr_busy, 1'b1);
    cmd(8'hAA, 1'b0);
    wt();
    u_setm_host.start();
    snd(8'hAA, 1'b1);
    snd(8'h20, 1'b1);
    u_setm_host.start();
    snd(8'hAB, 1'b1);
    for (int i = 0; i < 16; i++)
      rd(i == 15, 8'h40 + 8'(i));
    u_setm_host.stop();
    cmd(8'hA0, 1'b0);
    // lock blocks 0 and 2, refuse, unlock all, lock and unlock again
    hv <= 1'b1;
    cmd(8'h62, 1'b1);
    cmd(8'h6A, 1'b1);
    cmd(8'h62, 1'b0);
    hv <= 1'b0;
    cmd(8'h68, 1'b0);
    u_setm_host.start();
    snd(8'hAA, 1'b1);
    snd(8'h10, 1'b1);
    snd(8'h55, 1'b0);
    u_setm_host.stop();
    wt();
    pchk(8'h63, 1'b0);
    hv <= 1'b1;
    cmd(8'h66, 1'b1);
    pchk(8'h63, 1'b1);
    pchk(8'h6B, 1'b1);
    cmd(8'h62, 1'b1);
    pchk(8'h63, 1'b0);
    cmd(8'h66, 1'b1);
    pchk(8'h63, 1'b1);
    hv <= 1'b0;
    cmd(8'h64, 1'b0);
    for (int p = 0; p < 2; p++) begin
      cmd(8'h6C | 8'(p << 1), 1'b1);
      pchk(8'h6D | 8'(p << 1), 1'b1);
      pchk(8'h6F ^ 8'(p << 1), 1'b0);
    end
    // comparator event at both levels, reading, soft reset
    lim();
    tf(13'h0105);
    ck1(event_oe, 1'b1);
    tf(13'h0000);
    ck1(event_oe, 1'b0);
    tf(13'h1FF0);
    ck1(event_oe, 1'b1);
    tw(setm_pkg::PTR_CFG, 16'h0002);
    ck1(event_oe, 1'b0);
    tf(13'h0000);
    ck1(event_oe, 1'b1);
    tf(13'h0105);
    u_setm_host.start();
    snd(8'h3A, 1'b1);
    snd({4'h0, setm_pkg::PTR_TEMP}, 1'b1);
    u_setm_host.start();
    snd(8'h3B, 1'b1);
    rd(1'b0, 8'hC1);
    rd(1'b1, 8'h04);
    u_setm_host.stop();
    tw(setm_pkg::PTR_CFG, 16'h8000);
    ck1(event_oe, 1'b1);
    lim();
    // latched event survives the cause until cleared
    tf(13'h0000);
    tw(setm_pkg::PTR_CFG, 16'h0001);
    tf(13'h0105);
    ck1(event_oe, 1'b1);
    tf(13'h0000);
    ck1(event_oe, 1'b1);
    tw(setm_pkg::PTR_CFG, 16'h0021);
    ck1(event_oe, 1'b0);
    // six degrees of hysteresis hold the upper event at zero degrees
    tw(setm_pkg::PTR_CFG, 16'h0600);
    tf(13'h0105);
    tf(13'h0000);
    ck1(event_oe, 1'b1);
    tw(setm_pkg::PTR_CFG, 16'h0100);
    cc(c);
    chk(16'(c), 16'h0000);
    tw(setm_pkg::PTR_CFG, 16'h0000);
    cc(c);
    ck1(c > 1, 1'b1);
    summarize();
  end
endmodule // tb_top
